/* File: hw/t8w_clk_sel.sv */
// Timer clock-enable generator: free-running prescaler and count-pin edge detector.
// Assumes the count pin is asynchronous to pclk and slower than half its rate.
`timescale 1ns/1ps

module t8w_clk_sel #(
  parameter int PRESC_W = t8w_pkg::PRESC_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] clock_source_sel,
  input wire logic ext_count_input,
  output logic tick
);

  if (PRESC_W != 10) begin : g_chk
    $error("t8w_clk_sel needs a 10-bit prescaler.");
  end

  t8w_pkg::t8w_clk_state_t s_q;
  t8w_pkg::t8w_clk_state_t s_d;

  // Synchronise the pin, accept a level once two later stages agree, step the prescaler.
  always_comb begin
    s_d = s_q;
    s_d.s1 = ext_count_input; // R17
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3) begin
      s_d.filt = s_q.s3;
    end
    s_d.prev = s_q.filt;
    s_d.pre = s_q.pre + PRESC_W'(1);
  end

  // Select the enable source; taps fire once per divide period.
  always_comb begin
    unique case (clock_source_sel)
      t8w_pkg::CS_STOP: tick = 1'b0; // R15
      t8w_pkg::CS_DIV1: tick = 1'b1;
      t8w_pkg::CS_DIV8: tick = &(s_q.pre | ~t8w_pkg::TAP_8);
      t8w_pkg::CS_DIV64: tick = &(s_q.pre | ~t8w_pkg::TAP_64);
      t8w_pkg::CS_DIV256: tick = &(s_q.pre | ~t8w_pkg::TAP_256);
      t8w_pkg::CS_DIV1024: tick = &(s_q.pre | ~t8w_pkg::TAP_1024);
      t8w_pkg::CS_EXT_FALL: tick = s_q.prev & ~s_q.filt; // R16
      t8w_pkg::CS_EXT_RISE: tick = ~s_q.prev & s_q.filt; // R16
    endcase
  end

  // Register the state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

/* File: hw/t8w_pkg.sv */
// Shared constants and the state type of the 8-bit waveform timer.
// Assumes an APB slave at 32-bit data with one register to each aligned word.
//
// Notes on behaviour
// R01 - Any nonzero channel-B output mode connects wave_out_b to its pin.
// R02 - Software sets pin direction, else the waveform never reaches the pin.
// R03 - Non-PWM modes: B mode 00 off, 01 toggle, 10 clear, 11 set on match.
// R04 - Fast PWM: B mode 10 clears on match, sets at top; 11 reverse; 01 reserved.
// R05 - PWM with compare equal to top and mode bit 1: skip match, act at top.
// R06 - Phase correct: B mode 10 clears rising match, sets falling; 11 reverse.
// R07 - Unused control bits always read as zero.
// R08 - Waveform mode field picks normal, clear-on-match, fast or phase correct PWM.
// R09 - Compare writes act at once outside PWM, else load at top.
// R10 - Overflow flag at max, at bottom in phase correct, at top in mode 7.
// R11 - Force strobes apply a match action outside PWM modes only.
// R12 - Forced matches set no flag and never clear the counter.
// R13 - Force strobe bits always read back as zero.
// R14 - Software writes zero to force bits while a PWM mode runs.
// R15 - Clock select: stop, undivided, or prescaler divide by 8, 64, 256, 1024.
// R16 - Clock select 110 counts falling, 111 rising edges of the count pin.
// R17 - Count pin edges count even when that pin is an output.
// R18 - Software reads and writes the counter at any time.
// R19 - A counter write suppresses compare matches on the next timer tick.
// R20 - Compare value A is matched continuously for flag and wave_out_a.
// R21 - Channel-A mode 01 toggles in PWM only with waveform_mode_hi set.
// R22 - Phase correct counts up, holds top one tick, counts down, reverses.
// R23 - Match B flag set on match, cleared by vector acknowledge or write one.
// R24 - Normal and fast PWM count up and wrap after the active top.
package t8w_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMP_A = 8'h0C;
  localparam logic [7:0] OFS_CMP_B = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_B_FORCE_A = 7;
  localparam int CTRL_B_FORCE_B = 6;
  localparam int CTRL_B_MODE_HI = 3;
  localparam int FLAG_MATCH_B = 2;
  localparam int FLAG_MATCH_A = 1;
  localparam int FLAG_OVERFLOW = 0;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // Waveform modes.
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PC_MAX = 3'h1;
  localparam logic [2:0] MODE_CLR_MATCH = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_PC_CMP = 3'h5;
  localparam logic [2:0] MODE_FAST_CMP = 3'h7;

  // Clock select codes and prescaler tap masks.
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRESC_W = 10;
  localparam logic [9:0] TAP_8 = 10'h007;
  localparam logic [9:0] TAP_64 = 10'h03F;
  localparam logic [9:0] TAP_256 = 10'h0FF;
  localparam logic [9:0] TAP_1024 = 10'h3FF;

  // Timer state, registered as a whole.
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [1:0] mode_lo;
    logic mode_hi;
    logic [2:0] cs;
    logic [7:0] cnt;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b_buf;
    logic [7:0] cmp_b;
    logic down;
    logic blk;
    logic ovf;
    logic mfa;
    logic mfb;
    logic out_a;
    logic out_b;
    logic [31:0] rdata;
    logic err;
  } t8w_state_t;

  // Clock-enable generator state.
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic filt;
    logic prev;
    logic [PRESC_W-1:0] pre;
  } t8w_clk_state_t;

endpackage

/* File: hw/t8w_timer.sv */
// Top of the 8-bit timer with two waveform channels and an APB register file.
// Assumes an APB master on pclk; pin direction logic lies outside this block.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps

module t8w_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [t8w_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_input,
  input wire logic vec_ack_overflow,
  input wire logic vec_ack_match_a,
  input wire logic vec_ack_match_b,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_a_connected,
  output logic wave_b_connected,
  output logic overflow_flag,
  output logic match_a_flag,
  output logic match_b_flag
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // True for both fast and phase correct PWM modes.
  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = (m == t8w_pkg::MODE_PC_MAX) || (m == t8w_pkg::MODE_FAST_MAX) ||
             (m == t8w_pkg::MODE_PC_CMP) || (m == t8w_pkg::MODE_FAST_CMP);
  endfunction

  // True for the phase correct modes.
  function automatic logic is_pc(input logic [2:0] m);
    is_pc = (m == t8w_pkg::MODE_PC_MAX) || (m == t8w_pkg::MODE_PC_CMP);
  endfunction

  // Next output level of one channel for the given events.
  function automatic logic wave_next(
    input logic cur,
    input logic [1:0] com,
    input logic pwm,
    input logic pc,
    input logic hit,
    input logic top_ev,
    input logic down,
    input logic cmp_top,
    input logic tog_ok
  );
    logic r;
    r = cur;
    if (!pwm) begin
      if (hit) begin
        unique case (com)
          t8w_pkg::COM_OFF: r = cur; // R03
          t8w_pkg::COM_TOGGLE: r = ~cur; // R03
          t8w_pkg::COM_CLEAR: r = 1'b0; // R03
          t8w_pkg::COM_SET: r = 1'b1; // R03
        endcase
      end
    end else if (com[1]) begin
      if (pc) begin
        if (cmp_top) begin
          if (top_ev) begin
            r = ~com[0]; // R05
          end
        end else if (hit) begin
          r = down ? ~com[0] : com[0]; // R06
        end
      end else begin
        if (hit && !cmp_top) begin
          r = com[0]; // R04
        end
        if (top_ev) begin
          r = ~com[0]; // R04 R05
        end
      end
    end else if (com == t8w_pkg::COM_TOGGLE && tog_ok && hit) begin
      r = ~cur; // R21
    end
    wave_next = r;
  endfunction

  // ----------------------------------------------------------------
  // Timer clock enable
  // ----------------------------------------------------------------
  t8w_pkg::t8w_state_t s_q;
  t8w_pkg::t8w_state_t s_d;
  logic tick;

  t8w_clk_sel #(
    .PRESC_W(t8w_pkg::PRESC_W)
  ) u_clk_sel (
    .pclk(pclk),
    .presetn(presetn),
    .clock_source_sel(s_q.cs),
    .ext_count_input(ext_count_input),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Decode of mode and events
  // ----------------------------------------------------------------
  logic [2:0] mode;
  logic pwm;
  logic pc;
  logic top_from_cmp;
  logic [7:0] top;
  logic at_top;
  logic hit_a;
  logic hit_b;
  logic ovf_ev;
  logic wr;
  logic setup;

  // Mode class, active top and match events for this timer tick.
  always_comb begin
    mode = {s_q.mode_hi, s_q.mode_lo}; // R08
    pwm = is_pwm(mode);
    pc = is_pc(mode);
    top_from_cmp = (mode == t8w_pkg::MODE_CLR_MATCH) || (mode == t8w_pkg::MODE_PC_CMP) ||
                   (mode == t8w_pkg::MODE_FAST_CMP); // R08
    top = top_from_cmp ? s_q.cmp_a : t8w_pkg::CNT_MAX;
    at_top = s_q.cnt == top;
    hit_a = tick && !s_q.blk && (s_q.cnt == s_q.cmp_a); // R20 R19
    hit_b = tick && !s_q.blk && (s_q.cnt == s_q.cmp_b); // R19
    if (pc) begin
      ovf_ev = tick && s_q.down && (s_q.cnt == t8w_pkg::CNT_BOTTOM); // R10
    end else if (mode == t8w_pkg::MODE_FAST_CMP) begin
      ovf_ev = tick && at_top; // R10
    end else begin
      ovf_ev = tick && (s_q.cnt == t8w_pkg::CNT_MAX); // R10
    end
    wr = psel && penable && pwrite;
    setup = psel && !penable;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // Count on each timer tick.
    if (tick) begin
      s_d.blk = 1'b0;
      if (pc) begin
        if (!s_q.down) begin
          if (at_top) begin
            s_d.down = 1'b1; // R22
            s_d.cnt = (top == t8w_pkg::CNT_BOTTOM) ? s_q.cnt : s_q.cnt - t8w_pkg::CNT_ONE;
          end else begin
            s_d.cnt = s_q.cnt + t8w_pkg::CNT_ONE; // R22
          end
        end else if (s_q.cnt == t8w_pkg::CNT_BOTTOM) begin
          s_d.down = 1'b0; // R22
          s_d.cnt = (top == t8w_pkg::CNT_BOTTOM) ? s_q.cnt : t8w_pkg::CNT_ONE;
        end else begin
          s_d.cnt = s_q.cnt - t8w_pkg::CNT_ONE; // R22
        end
      end else begin
        s_d.down = 1'b0;
        s_d.cnt = at_top ? t8w_pkg::CNT_BOTTOM : s_q.cnt + t8w_pkg::CNT_ONE; // R24
      end
      if (pwm && at_top) begin
        s_d.cmp_a = s_q.cmp_a_buf; // R09
        s_d.cmp_b = s_q.cmp_b_buf; // R09
      end
    end

    // Drive both waveform outputs from matches and top events.
    s_d.out_a = wave_next(s_q.out_a, s_q.com_a, pwm, pc, hit_a, tick && at_top, s_q.down,
                          s_q.cmp_a == top, s_q.mode_hi); // R20 R21
    s_d.out_b = wave_next(s_q.out_b, s_q.com_b, pwm, pc, hit_b, tick && at_top, s_q.down,
                          s_q.cmp_b == top, 1'b0);

    // Flags: software write-one clear and vector acknowledge, then events win.
    if (wr && paddr == t8w_pkg::OFS_FLAGS) begin
      if (pwdata[t8w_pkg::FLAG_OVERFLOW]) begin
        s_d.ovf = 1'b0;
      end
      if (pwdata[t8w_pkg::FLAG_MATCH_A]) begin
        s_d.mfa = 1'b0;
      end
      if (pwdata[t8w_pkg::FLAG_MATCH_B]) begin
        s_d.mfb = 1'b0; // R23
      end
    end
    if (vec_ack_overflow) begin
      s_d.ovf = 1'b0;
    end
    if (vec_ack_match_a) begin
      s_d.mfa = 1'b0;
    end
    if (vec_ack_match_b) begin
      s_d.mfb = 1'b0; // R23
    end
    if (ovf_ev) begin
      s_d.ovf = 1'b1; // R10
    end
    if (hit_a) begin
      s_d.mfa = 1'b1; // R20
    end
    if (hit_b) begin
      s_d.mfb = 1'b1; // R23
    end

    // Register writes take effect in the access cycle.
    if (wr) begin
      unique case (paddr)
        t8w_pkg::OFS_CTRL_A: begin
          s_d.com_a = pwdata[7:6];
          s_d.com_b = pwdata[5:4];
          s_d.mode_lo = pwdata[1:0]; // R08
        end
        t8w_pkg::OFS_CTRL_B: begin
          s_d.mode_hi = pwdata[t8w_pkg::CTRL_B_MODE_HI]; // R08
          s_d.cs = pwdata[2:0]; // R15
          // Forced matches change only the outputs, never flags or count.
          if (!pwm && pwdata[t8w_pkg::CTRL_B_FORCE_A]) begin
            s_d.out_a = wave_next(s_d.out_a, s_q.com_a, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0,
                                  1'b0, 1'b0); // R11 R12
          end
          if (!pwm && pwdata[t8w_pkg::CTRL_B_FORCE_B]) begin
            s_d.out_b = wave_next(s_d.out_b, s_q.com_b, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0,
                                  1'b0, 1'b0); // R11 R12
          end
        end
        t8w_pkg::OFS_COUNT: begin
          s_d.cnt = pwdata[7:0]; // R18
          s_d.blk = 1'b1; // R19
        end
        t8w_pkg::OFS_CMP_A: begin
          s_d.cmp_a_buf = pwdata[7:0];
        end
        t8w_pkg::OFS_CMP_B: begin
          s_d.cmp_b_buf = pwdata[7:0];
        end
        default: begin
        end
      endcase
    end

    // Outside PWM the active compare values follow the written ones at once.
    if (!pwm) begin
      s_d.cmp_a = s_d.cmp_a_buf; // R09
      s_d.cmp_b = s_d.cmp_b_buf; // R09
    end

    // Read data and error are captured in the setup cycle.
    if (setup) begin
      s_d.err = 1'b0;
      unique case (paddr)
        t8w_pkg::OFS_CTRL_A: begin
          s_d.rdata = {24'h00_0000, s_q.com_a, s_q.com_b, 2'h0, s_q.mode_lo}; // R07
        end
        t8w_pkg::OFS_CTRL_B: begin
          s_d.rdata = {24'h00_0000, 4'h0, s_q.mode_hi, s_q.cs}; // R07 R13
        end
        t8w_pkg::OFS_COUNT: begin
          s_d.rdata = {24'h00_0000, s_q.cnt}; // R18
        end
        t8w_pkg::OFS_CMP_A: begin
          s_d.rdata = {24'h00_0000, s_q.cmp_a_buf};
        end
        t8w_pkg::OFS_CMP_B: begin
          s_d.rdata = {24'h00_0000, s_q.cmp_b_buf};
        end
        t8w_pkg::OFS_FLAGS: begin
          s_d.rdata = {29'h0000_0000, s_q.mfb, s_q.mfa, s_q.ovf};
        end
        default: begin
          s_d.rdata = t8w_pkg::RESET_WORD;
          s_d.err = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = s_q.err;
  assign prdata = s_q.rdata;

  // Pin override and flags. Direction stays with the port logic outside.
  assign wave_out_a = s_q.out_a;
  assign wave_out_b = s_q.out_b;
  assign wave_b_connected = s_q.com_b != t8w_pkg::COM_OFF; // R01 R02
  assign wave_a_connected = (s_q.com_a != t8w_pkg::COM_OFF) &&
                            !(pwm && s_q.com_a == t8w_pkg::COM_TOGGLE && !s_q.mode_hi); // R21
  assign overflow_flag = s_q.ovf;
  assign match_a_flag = s_q.mfa;
  assign match_b_flag = s_q.mfb;

endmodule

/* File: testbench/t8w_pin_model.sv */
// Far side of the timer: output pad of channel B and the count pin.
// Assumes a pull-up on pad B and a count source idle low outside bursts.
`timescale 1ns/1ps

module t8w_pin_model (
  input wire logic pclk,
  input wire logic wave_out_b,
  input wire logic wave_b_connected,
  input wire logic dir_b,
  input wire logic dir_t0,
  input wire logic port_t0,
  output logic pin_b,
  output logic ext_count_input
);
  logic src_q = 1'b0;

  // The pad shows the waveform only with its driver on; the pull-up wins otherwise.
  assign pin_b = (dir_b && wave_b_connected) ? wave_out_b : 1'b1;

  // An output-configured count pin still reaches the edge detector.
  assign ext_count_input = dir_t0 ? port_t0 : src_q;

  // Makes n full pulses, each level held four clocks, slower than half pclk.
  task automatic pulses(input int n);
    repeat (2 * n) begin
      repeat (4) @(posedge pclk);
      src_q <= ~src_q;
    end
  endtask
endmodule

/* File: testbench/t8w_timer_properties.sv */
// Concurrent checks on register reads, pin override and flag behaviour.
// Assumes only the ports of the timer top; bound in below the module.
`timescale 1ns/1ps

module t8w_timer_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [t8w_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic vec_ack_overflow,
  input wire logic vec_ack_match_b,
  input wire logic wave_b_connected,
  input wire logic overflow_flag,
  input wire logic match_a_flag,
  input wire logic match_b_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Access-phase decodes shared by the properties.
  logic rd_acc;
  logic wr_acc;
  logic clr_b;
  logic clr_o;
  assign rd_acc = psel && penable && !pwrite;
  assign wr_acc = psel && penable && pwrite;
  assign clr_b = wr_acc && paddr == t8w_pkg::OFS_FLAGS && pwdata[2];
  assign clr_o = wr_acc && paddr == t8w_pkg::OFS_FLAGS && pwdata[0];

  conn_b_a: assert property (
    wr_acc && paddr == t8w_pkg::OFS_CTRL_A |=> wave_b_connected == (|$past(pwdata[5:4])))
    else $error("channel B override differs from its mode field");
  ctrl_a_zero_a: assert property (
    rd_acc && paddr == t8w_pkg::OFS_CTRL_A |-> prdata[3:2] == 2'h0 && prdata[31:8] == 24'h0)
    else $error("unused control A bits read nonzero");
  ctrl_b_zero_a: assert property (
    rd_acc && paddr == t8w_pkg::OFS_CTRL_B |-> prdata[5:4] == 2'h0)
    else $error("unused control B bits read nonzero");
  force_zero_a: assert property (
    rd_acc && paddr == t8w_pkg::OFS_CTRL_B |-> prdata[7:6] == 2'h0)
    else $error("force strobes read nonzero");
  flag_read_a: assert property (
    rd_acc && paddr == t8w_pkg::OFS_FLAGS |->
      prdata[2:0] == {$past(match_b_flag), $past(match_a_flag), $past(overflow_flag)})
    else $error("flag register read differs from flag outputs");
  b_sticky_a: assert property (
    match_b_flag && !vec_ack_match_b && !clr_b |=> match_b_flag)
    else $error("match B flag dropped without a clear");
  ovf_sticky_a: assert property (
    overflow_flag && !vec_ack_overflow && !clr_o |=> overflow_flag)
    else $error("overflow flag dropped without a clear");
  cnt_block_a: assert property (
    wr_acc && paddr == t8w_pkg::OFS_COUNT |-> ##2 !$rose(match_a_flag) && !$rose(match_b_flag))
    else $error("compare match on the tick after a counter write");
endmodule

bind t8w_timer t8w_timer_checker u_t8w_timer_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .vec_ack_overflow, .vec_ack_match_b, .wave_b_connected,
  .overflow_flag, .match_a_flag, .match_b_flag
);

/* File: testbench/tb_top.sv */
// Self-checking bench for the 8-bit waveform timer, driven over APB.
// Assumes the pin model for the far side and the bound checker.
`timescale 1ns/1ps

module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [t8w_pkg::ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, ext_count_input, pin_b;
  logic vec_ack_match_b = 1'b0;
  logic dir_b = 1'b0;
  logic dir_t0 = 1'b0;
  logic port_t0 = 1'b0;
  logic wave_out_a, wave_out_b, wave_a_connected, wave_b_connected;
  logic overflow_flag, match_a_flag, match_b_flag;
  logic [31:0] rdv;
  logic last_err;
  int err_count = 0;
  int n_checks = 0;

  // Free-running 125 MHz clock.
  always #4 pclk = ~pclk;

  t8w_timer u_t8w_timer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_input(ext_count_input), .vec_ack_overflow(1'b0), .vec_ack_match_a(1'b0),
    .vec_ack_match_b(vec_ack_match_b), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .wave_a_connected(wave_a_connected), .wave_b_connected(wave_b_connected),
    .overflow_flag(overflow_flag), .match_a_flag(match_a_flag), .match_b_flag(match_b_flag)
  );

  t8w_pin_model u_t8w_pin_model (
    .pclk(pclk), .wave_out_b(wave_out_b), .wave_b_connected(wave_b_connected),
    .dir_b(dir_b), .dir_t0(dir_t0), .port_t0(port_t0), .pin_b(pin_b),
    .ext_count_input(ext_count_input)
  );

  // --------------------------------------------------------------
  // Access and checking tasks
  // --------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      err_count++;
      summarize();
    end
    rdv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(name, rdv, exp);
  endtask

  // Waits for match B (1) or overflow (0), bounded.
  task automatic wait_flag(input int which);
    int n;
    n = 0;
    while ((which ? match_b_flag : overflow_flag) !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) begin
      err_count++;
      summarize();
    end
  endtask

  task automatic port_pulses(input int n);
    repeat (2 * n) begin
      repeat (4) @(posedge pclk);
      port_t0 <= ~port_t0;
    end
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    int i;
    int c;
    logic [1:0] coms [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
    int divs [4] = '{8, 64, 256, 1024};
    logic [7:0] pcmp [5] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'hFF};
    logic [1:0] pcom [5] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h2};
    logic [1:0] pmode [5] = '{2'h3, 2'h3, 2'h1, 2'h1, 2'h3};
    int pwin [5] = '{512, 512, 1020, 1020, 512};
    int pexp [5] = '{130, 382, 256, 764, 512};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl_a_reset", t8w_pkg::OFS_CTRL_A, 32'h0000_0000);
    rdc("ctrl_b_reset", t8w_pkg::OFS_CTRL_B, 32'h0000_0000);
    rdc("cmp_a_reset", t8w_pkg::OFS_CMP_A, 32'h0000_0000);
    apb(1'b0, 8'h18, 32'h0000_0000);
    check("unmapped_err", last_err, 32'h0000_0001);
    check("unmapped_data", rdv, 32'h0000_0000);
    wr(t8w_pkg::OFS_CTRL_A, 32'h0000_00FF);
    rdc("ctrl_a_bits", t8w_pkg::OFS_CTRL_A, 32'h0000_00F3);
    check("a_connected", wave_a_connected, 32'h0000_0001);
    wr(t8w_pkg::OFS_CTRL_B, 32'h0000_00C8);
    rdc("ctrl_b_bits", t8w_pkg::OFS_CTRL_B, 32'h0000_0008);
    check("pwm_force_b", wave_out_b, 32'h0000_0000);
    // Forced matches in clear-on-match mode, output mode codes 01, 10 and 11.
    wr(t8w_pkg::OFS_CTRL_B, 32'h0000_0000);
    wr(t8w_pkg::OFS_COUNT, 32'h0000_005A);
    rdc("count_rw", t8w_pkg::OFS_COUNT, 32'h0000_005A);
    for (i = 0; i < 4; i++) begin
      wr(t8w_pkg::OFS_CTRL_A, {24'h0, 2'h0, coms[i], 4'h2});
      wr(t8w_pkg::OFS_CTRL_B, 32'h0000_0040);
      repeat (2) @(posedge pclk);
      check("force_b_level", wave_out_b, {31'h0, ~i[0]});
      check("pin_b_override", wave_b_connected, 32'h0000_0001);
    end
    rdc("force_no_flag", t8w_pkg::OFS_FLAGS, 32'h0000_0000);
    rdc("force_no_clear", t8w_pkg::OFS_COUNT, 32'h0000_005A);
    wr(t8w_pkg::OFS_CTRL_A, 32'h0000_00E2);
    wr(t8w_pkg::OFS_CTRL_B, 32'h0000_0080);
    repeat (2) @(posedge pclk);
    check("force_a_level", wave_out_a, 32'h0000_0001);
    check("pin_b_pulled", pin_b, 32'h0000_0001);
    dir_b <= 1'b1;
    repeat (2) @(posedge pclk);
    check("pin_b_driven", pin_b, 32'h0000_0000);
    // Counter write blocks the next match; flags set and clear.
    wr(t8w_pkg::OFS_CTRL_A, 32'h0000_0000);
    wr(t8w_pkg::OFS_CMP_B, 32'h0000_0010);
    wr(t8w_pkg::OFS_COUNT, 32'h0000_0080);
    wr(t8w_pkg::OFS_CTRL_B, 32'h0000_0001);
    wr(t8w_pkg::OFS_FLAGS, 32'h0000_0007);
    wr(t8w_pkg::OFS_COUNT, 32'h0000_0010);
    apb(1'b0, t8w_pkg::OFS_FLAGS, 32'h0000_0000);
    check("blocked_match", rdv[2], 32'h0000_0000);
    wait_flag(1);
    apb(1'b0, t8w_pkg::OFS_COUNT, 32'h0000_0000);
    check("match_b_time", rdv > 32'h0000_0010 && rdv < 32'h0000_0018, 32'h0000_0001);
    vec_ack_match_b <= 1'b1;
    @(posedge pclk);
    vec_ack_match_b <= 1'b0;
    repeat (2) @(posedge pclk);
    check("ack_clears_b", match_b_flag, 32'h0000_0000);
    wr(t8w_pkg::OFS_FLAGS, 32'h0000_0001);
    @(posedge pclk);
    check("w1c_ovf", overflow_flag, 32'h0000_0000);
    wait_flag(0);
    apb(1'b0, t8w_pkg::OFS_COUNT, 32'h0000_0000);
    check("ovf_at_max", rdv < 32'h0000_0008, 32'h0000_0001);
    // Prescaler taps: four to five ticks in four periods.
    for (i = 0; i < 4; i++) begin
      wr(t8w_pkg::OFS_CTRL_B, 32'h0000_0000);
      wr(t8w_pkg::OFS_COUNT, 32'h0000_0000);
      wr(t8w_pkg::OFS_CTRL_B, {29'h0, 3'(i + 2)});
      repeat (4 * divs[i]) @(posedge pclk);
      wr(t8w_pkg::OFS_CTRL_B, 32'h0000_0000);
      apb(1'b0, t8w_pkg::OFS_COUNT, 32'h0000_0000);
      check("prescale_ticks", rdv == 4 || rdv == 5, 32'h0000_0001);
    end
    // Count pin edges, as input and as output.
    for (i = 0; i < 2; i++) begin
      wr(t8w_pkg::OFS_COUNT, 32'h0000_0000);
      dir_t0 <= i[0];
      wr(t8w_pkg::OFS_CTRL_B, {29'h0, 3'(6 + i)});
      if (i == 1) begin
        port_pulses(3);
      end else begin
        u_t8w_pin_model.pulses(3);
      end
      repeat (8) @(posedge pclk);
      rdc("ext_edges", t8w_pkg::OFS_COUNT, 32'h0000_0003);
      wr(t8w_pkg::OFS_CTRL_B, 32'h0000_0000);
    end
    // PWM high time over whole periods.
    wr(t8w_pkg::OFS_CTRL_B, 32'h0000_0001);
    for (i = 0; i < 5; i++) begin
      wr(t8w_pkg::OFS_CMP_B, {24'h0, pcmp[i]});
      wr(t8w_pkg::OFS_CTRL_A, {26'h0, pcom[i], 2'h0, pmode[i]});
      repeat (1100) @(posedge pclk);
      c = 0;
      repeat (pwin[i]) begin
        @(negedge pclk);
        c += (wave_out_b === 1'b1);
      end
      check("pwm_high_time", c, pexp[i]);
    end
    summarize();
  end
endmodule
